// >>> ldag_pkg.sv
// Shared constants, encodings and carrier types for the load decode and address generator
package ldag_pkg;

    // ************************************************************
    // Data widths
    // ************************************************************
    localparam int XLEN = 32;
    localparam int INSTR_W = 16;
    localparam int REG_IDX_W = 3;

    // ************************************************************
    // Opcode fields and values
    // ************************************************************
    localparam int OPC7_LSB = 9;
    localparam int OPC7_W = 7;
    localparam int OPC5_LSB = 11;
    localparam int OPC5_W = 5;
    localparam logic [6:0] OPC7_WORD_REG = 7'h2C;
    localparam logic [6:0] OPC7_HALF_REG = 7'h2D;
    localparam logic [6:0] OPC7_BYTE_REG = 7'h2E;
    localparam logic [4:0] OPC5_BYTE_IMM = 5'h0F;
    localparam logic [4:0] OPC5_HALF_IMM = 5'h11;
    localparam logic [4:0] OPC5_WORD_LIT = 5'h09;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int DEST_LSB = 0;
    localparam int BASE_LSB = 3;
    localparam int OFFR_LSB = 6;
    localparam int SHORT_OFF_LSB = 6;
    localparam int SHORT_OFF_W = 5;
    localparam int LONG_OFF_LSB = 0;
    localparam int LONG_OFF_W = 8;
    localparam int LIT_DEST_LSB = 8;
    localparam int BYTE_W = 8;
    localparam int HALF_W = 16;

    // Largest literal offset and the word alignment mask
    localparam logic [31:0] LIT_OFFSET_MAX = 32'h0000_03FC;
    localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        LDAG_SIZE_BYTE = 3'h1,
        LDAG_SIZE_HALF = 3'h2,
        LDAG_SIZE_WORD = 3'h4
    } ldag_size_t;

    typedef struct packed {
        logic valid;
        ldag_size_t size;
        logic use_pc;
        logic use_reg_off;
        logic [2:0] dest_reg_field;
        logic [2:0] base_reg_field;
        logic [2:0] offset_reg_field;
        logic [31:0] imm;
    } ldag_dec_t;

    typedef enum logic [1:0] {
        LDAG_IDLE = 2'h0,
        LDAG_READ = 2'h1,
        LDAG_WAIT = 2'h3,
        LDAG_WRITE = 2'h2
    } ldag_state_t;

endpackage : ldag_pkg

// >>> ldag_decoder.sv
// Combinational decoder for the 16-bit load forms handled by this block
`timescale 1ns/1ps
module ldag_decoder (
    input wire logic [ldag_pkg::INSTR_W-1:0] i_instr, // Instruction halfword
    output ldag_pkg::ldag_dec_t o_dec // Decoded fields
);
    import ldag_pkg::*;

    logic [OPC7_W-1:0] opc7;
    logic [OPC5_W-1:0] opc5;

    // Opcode slices
    assign opc7 = i_instr[OPC7_LSB +: OPC7_W];
    assign opc5 = i_instr[OPC5_LSB +: OPC5_W];

    // Field extraction; anything unmatched leaves valid low
    always_comb begin
        o_dec = '0;
        o_dec.size = LDAG_SIZE_WORD;
        o_dec.dest_reg_field = i_instr[DEST_LSB +: REG_IDX_W];
        o_dec.base_reg_field = i_instr[BASE_LSB +: REG_IDX_W];
        o_dec.offset_reg_field = i_instr[OFFR_LSB +: REG_IDX_W];
        if (opc7 == OPC7_WORD_REG) begin
            o_dec.valid = 1'b1;
            o_dec.use_reg_off = 1'b1;
            o_dec.size = LDAG_SIZE_WORD;
        end else if (opc7 == OPC7_BYTE_REG) begin
            o_dec.valid = 1'b1;
            o_dec.use_reg_off = 1'b1;
            o_dec.size = LDAG_SIZE_BYTE;
        end else if (opc7 == OPC7_HALF_REG) begin
            o_dec.valid = 1'b1;
            o_dec.use_reg_off = 1'b1;
            o_dec.size = LDAG_SIZE_HALF;
        end else if (opc5 == OPC5_BYTE_IMM) begin
            o_dec.valid = 1'b1;
            o_dec.size = LDAG_SIZE_BYTE;
            o_dec.imm = 32'(i_instr[SHORT_OFF_LSB +: SHORT_OFF_W]);
        end else if (opc5 == OPC5_HALF_IMM) begin
            o_dec.valid = 1'b1;
            o_dec.size = LDAG_SIZE_HALF;
            o_dec.imm = 32'({i_instr[SHORT_OFF_LSB +: SHORT_OFF_W], 1'b0});
        end else if (opc5 == OPC5_WORD_LIT) begin
            o_dec.valid = 1'b1;
            o_dec.use_pc = 1'b1;
            o_dec.size = LDAG_SIZE_WORD;
            o_dec.dest_reg_field = i_instr[LIT_DEST_LSB +: REG_IDX_W];
            o_dec.imm = 32'({i_instr[LONG_OFF_LSB +: LONG_OFF_W], 2'h0});
        end
    end

endmodule : ldag_decoder

// >>> ldag_extend.sv
// Zero extension of returned load data by access size
`timescale 1ns/1ps
module ldag_extend (
    input wire logic [ldag_pkg::XLEN-1:0] i_rdata, // Data, item in low bits
    input ldag_pkg::ldag_size_t i_size, // Access size
    output logic [ldag_pkg::XLEN-1:0] o_wdata // Zero-extended result
);
    import ldag_pkg::*;

    // Upper bits cleared for byte and halfword sizes, word passes unchanged; no signed forms live here
    always_comb begin
        unique case (i_size)
            LDAG_SIZE_BYTE: o_wdata = XLEN'(i_rdata[BYTE_W-1:0]);
            LDAG_SIZE_HALF: o_wdata = XLEN'(i_rdata[HALF_W-1:0]);
            default: o_wdata = i_rdata;
        endcase
    end

endmodule : ldag_extend

// >>> ldag_core.sv
// Load decode and address generator: decode, address, read, zero-extend, write back
//
// Function
// - Literal load address is PC rounded down to four plus offset 0..1020.
// - Literal offset is eight-bit field with two zero bits appended, always added.
// - Register word load adds base and offset registers, reads four bytes to destination.
// - Register word load decoded at 0101100; offset 8:6, base 5:3, destination 2:0.
// - Immediate byte load adds unscaled five-bit offset 0..31 to base register.
// - Immediate byte load decoded at 01111; offset 10:6, base 5:3, destination 2:0.
// - Register byte load decoded at 0101110; base plus offset register, one byte read.
// - Byte loads clear the upper 24 bits of the destination.
// - Immediate halfword load decoded at 10001; five-bit offset doubled, added to base.
// - Halfword loads read two bytes and zero-extend to 32 bits.
// - Register halfword load decoded at 0101101 with the usual register fields.
// - All forms use added offset and never write the address back to base.
// - Offset register is shifted left by zero, so raw contents are added.
`timescale 1ns/1ps
module ldag_core (
    input wire logic i_clk, // Core clock, 25 MHz
    input wire logic i_reset_n, // Async reset, active low
    input wire logic i_instr_valid, // Instruction offered
    input wire logic [ldag_pkg::INSTR_W-1:0] i_instr, // Instruction halfword
    input wire logic [ldag_pkg::XLEN-1:0] i_instr_pc, // PC value of the instruction
    output logic o_instr_ready, // Ready to take an instruction
    output logic o_decode_fault, // Pulse: unsupported encoding
    output logic o_busy, // Load in progress
    output logic [ldag_pkg::REG_IDX_W-1:0] o_rf_raddr_a, // Base register index
    output logic [ldag_pkg::REG_IDX_W-1:0] o_rf_raddr_b, // Offset register index
    input wire logic [ldag_pkg::XLEN-1:0] i_rf_rdata_a, // Base register value
    input wire logic [ldag_pkg::XLEN-1:0] i_rf_rdata_b, // Offset register value
    output logic o_mem_req, // Read request, held until data
    output logic [ldag_pkg::XLEN-1:0] o_mem_addr, // Byte address
    output ldag_pkg::ldag_size_t o_mem_size, // Bytes to read
    input wire logic i_mem_rvalid, // Read data returned
    input wire logic [ldag_pkg::XLEN-1:0] i_mem_rdata, // Read data, item in low bits
    output logic o_rf_we, // Pulse: destination write
    output logic [ldag_pkg::REG_IDX_W-1:0] o_rf_waddr, // Destination index
    output logic [ldag_pkg::XLEN-1:0] o_rf_wdata // Destination value
);
    import ldag_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    ldag_state_t state_reg;
    ldag_state_t state_next;
    ldag_dec_t dec_now;
    ldag_dec_t dec_reg;
    logic [XLEN-1:0] pc_reg;
    logic [XLEN-1:0] base_val;
    logic [XLEN-1:0] off_val;
    logic [XLEN-1:0] ext_data;
    logic accept;
    logic data_in;

    // ************************************************************
    // Submodules
    // ************************************************************
    ldag_decoder u_decoder (
        .i_instr(i_instr),
        .o_dec(dec_now)
    );

    ldag_extend u_extend (
        .i_rdata(i_mem_rdata),
        .i_size(dec_reg.size),
        .o_wdata(ext_data)
    );

    // ************************************************************
    // Handshakes and operand selection
    // ************************************************************
    // Instruction taken only while idle; memory data counts only while waiting
    assign accept = i_instr_valid && o_instr_ready && (state_reg == LDAG_IDLE);
    assign data_in = i_mem_rvalid && o_mem_req && (state_reg == LDAG_WAIT);

    // Literal base is the aligned PC; register forms add the raw offset register
    assign base_val = dec_reg.use_pc ? (pc_reg & WORD_ALIGN_MASK) : i_rf_rdata_a;
    assign off_val = dec_reg.use_reg_off ? i_rf_rdata_b : dec_reg.imm;

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LDAG_IDLE: begin
                if (accept && dec_now.valid) begin
                    state_next = LDAG_READ;
                end
            end
            LDAG_READ: state_next = LDAG_WAIT;
            LDAG_WAIT: begin
                if (data_in) begin
                    state_next = LDAG_WRITE;
                end
            end
            LDAG_WRITE: state_next = LDAG_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= LDAG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Busy mirrors any non-idle state, registered for a clean output
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_next != LDAG_IDLE);
        end
    end

    // Ready drops on acceptance, returns after the write cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_instr_ready <= 1'b1;
        end else if (accept && dec_now.valid) begin
            o_instr_ready <= 1'b0;
        end else if (state_reg == LDAG_WRITE) begin
            o_instr_ready <= 1'b1;
        end
    end

    // Unsupported encodings are refused with a one-cycle pulse
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_decode_fault <= 1'b0;
        end else begin
            o_decode_fault <= accept && !dec_now.valid;
        end
    end

    // ************************************************************
    // Decode capture and register file read
    // ************************************************************
    // Held for the whole load so fields stay stable to write-back
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dec_reg <= '0;
            pc_reg <= '0;
            o_rf_raddr_a <= '0;
            o_rf_raddr_b <= '0;
        end else if (accept && dec_now.valid) begin
            dec_reg <= dec_now;
            pc_reg <= i_instr_pc;
            o_rf_raddr_a <= dec_now.base_reg_field;
            o_rf_raddr_b <= dec_now.offset_reg_field;
        end
    end

    // ************************************************************
    // Memory request
    // ************************************************************
    // Address is always base plus offset; no subtract path exists
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mem_req <= 1'b0;
            o_mem_addr <= '0;
            o_mem_size <= LDAG_SIZE_WORD;
        end else if (state_reg == LDAG_READ) begin
            o_mem_req <= 1'b1;
            o_mem_addr <= base_val + off_val;
            o_mem_size <= dec_reg.size;
        end else if (data_in) begin
            o_mem_req <= 1'b0;
        end
    end

    // ************************************************************
    // Destination write
    // ************************************************************
    // Only the destination is written; the base is never updated
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rf_we <= 1'b0;
            o_rf_waddr <= '0;
            o_rf_wdata <= '0;
        end else if (data_in) begin
            o_rf_we <= 1'b1;
            o_rf_waddr <= dec_reg.dest_reg_field;
            o_rf_wdata <= ext_data;
        end else begin
            o_rf_we <= 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    lit_addr_calc_a: assert property ($rose(o_mem_req) && dec_reg.use_pc |->
        o_mem_addr == (pc_reg & WORD_ALIGN_MASK) + dec_reg.imm && o_mem_addr[1:0] == 2'h0)
        else $error("literal address wrong");

    lit_offset_form_a: assert property (accept && i_instr[OPC5_LSB +: OPC5_W] == OPC5_WORD_LIT |=>
        dec_reg.imm == 32'({$past(i_instr[LONG_OFF_LSB +: LONG_OFF_W]), 2'h0}) && dec_reg.imm <= LIT_OFFSET_MAX)
        else $error("literal offset wrong");

    reg_addr_sum_a: assert property ($rose(o_mem_req) && dec_reg.use_reg_off |->
        o_mem_addr == $past(i_rf_rdata_a) + $past(i_rf_rdata_b))
        else $error("register address wrong");

    word_reg_dec_a: assert property (accept && i_instr[OPC7_LSB +: OPC7_W] == OPC7_WORD_REG |=>
        dec_reg.size == LDAG_SIZE_WORD && dec_reg.use_reg_off && o_rf_raddr_b == $past(i_instr[8:6])
        && o_rf_raddr_a == $past(i_instr[5:3]) && dec_reg.dest_reg_field == $past(i_instr[2:0]))
        else $error("word register decode wrong");

    byte_imm_addr_a: assert property ($rose(o_mem_req) && !dec_reg.use_reg_off && !dec_reg.use_pc
        && o_mem_size == LDAG_SIZE_BYTE |-> o_mem_addr == $past(i_rf_rdata_a) + dec_reg.imm && dec_reg.imm < 32'h20)
        else $error("byte immediate address wrong");

    byte_imm_dec_a: assert property (accept && i_instr[OPC5_LSB +: OPC5_W] == OPC5_BYTE_IMM |=>
        dec_reg.size == LDAG_SIZE_BYTE && dec_reg.imm == 32'($past(i_instr[10:6])))
        else $error("byte immediate decode wrong");

    byte_reg_dec_a: assert property (accept && i_instr[OPC7_LSB +: OPC7_W] == OPC7_BYTE_REG |=>
        dec_reg.size == LDAG_SIZE_BYTE && dec_reg.use_reg_off ##1 o_mem_size == LDAG_SIZE_BYTE)
        else $error("byte register decode wrong");

    narrow_zero_ext_a: assert property (o_rf_we && o_mem_size != LDAG_SIZE_WORD |->
        o_rf_wdata[XLEN-1:HALF_W] == '0 && (o_mem_size == LDAG_SIZE_HALF || o_rf_wdata[HALF_W-1:BYTE_W] == '0))
        else $error("zero extension wrong");

    half_imm_dec_a: assert property (accept && i_instr[OPC5_LSB +: OPC5_W] == OPC5_HALF_IMM |=>
        dec_reg.size == LDAG_SIZE_HALF && dec_reg.imm == 32'({$past(i_instr[10:6]), 1'b0}))
        else $error("halfword immediate decode wrong");

    half_reg_dec_a: assert property (accept && i_instr[OPC7_LSB +: OPC7_W] == OPC7_HALF_REG |=>
        dec_reg.size == LDAG_SIZE_HALF && o_rf_raddr_b == $past(i_instr[8:6]) && o_rf_raddr_a == $past(i_instr[5:3]))
        else $error("halfword register decode wrong");

    single_write_a: assert property (o_rf_we |-> o_rf_waddr == dec_reg.dest_reg_field ##1 !o_rf_we)
        else $error("extra register write");

    write_after_data_a: assert property (o_rf_we |-> $past(data_in) && !o_mem_req)
        else $error("write before data");

    // Address and size must not move while the read is still outstanding
    req_hold_a: assert property (o_mem_req && !i_mem_rvalid |=> o_mem_req && $stable(o_mem_addr)
        && $stable(o_mem_size)) else $error("request not held");

    // Ready and busy are two views of one load slot
    ready_busy_a: assert property (o_busy != o_instr_ready)
        else $error("ready and busy disagree");

    // A refused encoding must leave memory and register file untouched
    fault_quiet_a: assert property (o_decode_fault |-> !o_mem_req && !o_rf_we && o_instr_ready)
        else $error("fault with memory traffic");

endmodule : ldag_core

// >>> ldag_mem_model.sv
// Partner model: register file read ports and a memory that answers after a set delay
`timescale 1ns/1ps
module ldag_mem_model (
    input wire logic i_clk, // Core clock
    input wire logic i_reset_n, // Async reset, active low
    input wire logic [2:0] i_raddr_a, // Base register index
    input wire logic [2:0] i_raddr_b, // Offset register index
    output logic [31:0] o_rdata_a, // Base register value
    output logic [31:0] o_rdata_b, // Offset register value
    input wire logic i_mem_req, // Read request from the block
    input wire logic [31:0] i_delay, // Wait cycles before answering
    input wire logic [31:0] i_fill, // Word returned for the read
    output logic o_rvalid, // Data returned pulse
    output logic [31:0] o_rdata // Read data
);
    logic [31:0] regs [8];
    logic [31:0] wait_reg;

    // ************************************************************
    // Register file
    // ************************************************************
    // Reads are combinational, as the core expects
    assign o_rdata_a = regs[i_raddr_a];
    assign o_rdata_b = regs[i_raddr_b];

    // ************************************************************
    // Memory responder
    // ************************************************************
    // Outside the answer cycle the lines carry the inverse, so stale data cannot pass
    assign o_rdata = o_rvalid ? i_fill : ~i_fill;

    // One pulse per request after i_delay idle cycles, then quiet until the next request
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rvalid <= 1'h0;
            wait_reg <= 32'h0;
        end else if (i_mem_req && !o_rvalid) begin
            if (wait_reg == i_delay) begin
                o_rvalid <= 1'h1;
                wait_reg <= 32'h0;
            end else begin
                wait_reg <= wait_reg + 32'h1;
            end
        end else begin
            o_rvalid <= 1'h0;
            wait_reg <= 32'h0;
        end
    end
endmodule : ldag_mem_model

// >>> ldag_core_tb_top.sv
// Self-checking testbench for the load decode and address generator
`timescale 1ns/1ps
module ldag_core_tb_top;
    import ldag_pkg::*;

    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic instr_valid = 1'h0;
    logic [15:0] instr = 16'h0;
    logic [31:0] instr_pc = 32'h0;
    logic [31:0] delay = 32'h0;
    logic [31:0] fill = 32'h0;
    logic instr_ready, decode_fault, busy, mem_req, mem_rvalid, rf_we;
    logic [2:0] raddr_a, raddr_b, rf_waddr;
    logic [31:0] rdata_a, rdata_b, mem_addr, mem_rdata, rf_wdata;
    ldag_size_t mem_size;
    logic [31:0] seen_addr, seen_size, seen_waddr, seen_wdata;
    int err_count = 0;
    int cmp_count = 0;

    // ************************************************************
    // Clock, design and partner
    // ************************************************************
    // 25 MHz core clock
    always #20 clk = ~clk;

    ldag_core dut (.i_clk(clk), .i_reset_n(reset_n), .i_instr_valid(instr_valid), .i_instr(instr),
        .i_instr_pc(instr_pc), .o_instr_ready(instr_ready), .o_decode_fault(decode_fault), .o_busy(busy),
        .o_rf_raddr_a(raddr_a), .o_rf_raddr_b(raddr_b), .i_rf_rdata_a(rdata_a), .i_rf_rdata_b(rdata_b),
        .o_mem_req(mem_req), .o_mem_addr(mem_addr), .o_mem_size(mem_size), .i_mem_rvalid(mem_rvalid),
        .i_mem_rdata(mem_rdata), .o_rf_we(rf_we), .o_rf_waddr(rf_waddr), .o_rf_wdata(rf_wdata));

    ldag_mem_model pm (.i_clk(clk), .i_reset_n(reset_n), .i_raddr_a(raddr_a), .i_raddr_b(raddr_b),
        .o_rdata_a(rdata_a), .o_rdata_b(rdata_b), .i_mem_req(mem_req), .i_delay(delay), .i_fill(fill),
        .o_rvalid(mem_rvalid), .o_rdata(mem_rdata));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compare one value and count it
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Offer one load, then capture request and write-back; bounded waits avoid hangs
    task automatic do_load(input logic [15:0] ins, input logic [31:0] pc, input logic [31:0] dly,
        input logic [31:0] data);
        int n;
        @(posedge clk);
        instr_valid <= 1'h1;
        instr <= ins;
        instr_pc <= pc;
        delay <= dly;
        fill <= data;
        @(posedge clk);
        instr_valid <= 1'h0;
        for (n = 0; n < 50 && !(mem_req === 1'h1); n++) @(negedge clk);
        seen_addr = mem_addr;
        seen_size = 32'(mem_size);
        check("busy", 32'(busy), 32'h1);
        for (n = 0; n < 50 && !(rf_we === 1'h1); n++) begin
            @(negedge clk);
            if (rf_we !== 1'h1) check("addr held", mem_addr, seen_addr);
        end
        check("write pulse", 32'(rf_we), 32'h1);
        check("req dropped", 32'(mem_req), 32'h0);
        seen_waddr = 32'(rf_waddr);
        seen_wdata = rf_wdata;
        @(negedge clk);
        check("ready again", 32'(instr_ready), 32'h1);
        check("idle again", 32'(busy), 32'h0);
    endtask : do_load

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Literal load, largest offset and an unaligned PC, then zero offset
    task automatic t_literal();
        do_load(16'h4DFF, 32'h0000_1003, 32'h2, 32'hDEAD_BEEF);
        check("lit addr", seen_addr, 32'h0000_13FC);
        check("lit size", seen_size, 32'h4);
        check("lit dest", seen_waddr, 32'h5);
        check("lit data", seen_wdata, 32'hDEAD_BEEF);
        do_load(16'h4800, 32'h0000_2002, 32'h0, 32'h1357_9BDF);
        check("lit addr0", seen_addr, 32'h0000_2000);
    endtask : t_literal

    // Register word load with an unaligned offset that must not be shifted
    task automatic t_reg_word();
        pm.regs[1] = 32'h1000_0000;
        pm.regs[2] = 32'h0000_0123;
        do_load(16'h588B, 32'h0, 32'h3, 32'hCAFE_F00D);
        check("rw addr", seen_addr, 32'h1000_0123);
        check("rw size", seen_size, 32'h4);
        check("rw dest", seen_waddr, 32'h3);
        check("rw data", seen_wdata, 32'hCAFE_F00D);
    endtask : t_reg_word

    // Byte loads: largest short offset, then register form wrapping past zero
    task automatic t_bytes();
        pm.regs[4] = 32'h2000_0001;
        do_load(16'h7FE0, 32'h0, 32'h1, 32'hFFFF_FF9A);
        check("bi addr", seen_addr, 32'h2000_0020);
        check("bi size", seen_size, 32'h1);
        check("bi dest", seen_waddr, 32'h0);
        check("bi data", seen_wdata, 32'h0000_009A);
        pm.regs[6] = 32'hFFFF_FFFF;
        pm.regs[7] = 32'h0000_0002;
        do_load(16'h5DF1, 32'h0, 32'h0, 32'h1234_5680);
        check("br addr", seen_addr, 32'h0000_0001);
        check("br size", seen_size, 32'h1);
        check("br dest", seen_waddr, 32'h1);
        check("br data", seen_wdata, 32'h0000_0080);
    endtask : t_bytes

    // Halfword loads: doubled short offset, then register form on register zero
    task automatic t_halves();
        pm.regs[1] = 32'h1000_0000;
        do_load(16'h8FCA, 32'h0, 32'h4, 32'hABCD_8001);
        check("hi addr", seen_addr, 32'h1000_003E);
        check("hi size", seen_size, 32'h2);
        check("hi dest", seen_waddr, 32'h2);
        check("hi data", seen_wdata, 32'h0000_8001);
        pm.regs[0] = 32'h0000_0040;
        do_load(16'h5A07, 32'h0, 32'h0, 32'hFFFF_FFFF);
        check("hr addr", seen_addr, 32'h0000_0080);
        check("hr size", seen_size, 32'h2);
        check("hr dest", seen_waddr, 32'h7);
        check("hr data", seen_wdata, 32'h0000_FFFF);
    endtask : t_halves

    // Back-to-back forms outside this block: fault pulses, no memory traffic
    task automatic t_faults();
        logic [15:0] bad [3];
        bad = '{16'h6800, 16'h5E00, 16'h5600};
        foreach (bad[i]) begin
            @(posedge clk);
            instr_valid <= 1'h1;
            instr <= bad[i];
            @(negedge clk);
            if (i > 0) check("fault", 32'(decode_fault), 32'h1);
            check("no req", 32'(mem_req), 32'h0);
            check("ready kept", 32'(instr_ready), 32'h1);
        end
        @(posedge clk);
        instr_valid <= 1'h0;
        @(negedge clk);
        check("fault last", 32'(decode_fault), 32'h1);
        check("not busy", 32'(busy), 32'h0);
        @(negedge clk);
        check("fault end", 32'(decode_fault), 32'h0);
    endtask : t_faults

    // Reset in the middle of a load, then a clean load right after release
    task automatic t_reset_mid();
        pm.regs[1] = 32'h0000_0100;
        pm.regs[2] = 32'h0000_0000;
        @(posedge clk);
        instr_valid <= 1'h1;
        instr <= 16'h588B;
        delay <= 32'h8;
        @(posedge clk);
        instr_valid <= 1'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'h0;
        @(negedge clk);
        check("rst req", 32'(mem_req), 32'h0);
        check("rst ready", 32'(instr_ready), 32'h1);
        check("rst busy", 32'(busy), 32'h0);
        @(posedge clk);
        reset_n <= 1'h1;
        do_load(16'h588B, 32'h0, 32'h0, 32'h0000_5A5A);
        check("post rst addr", seen_addr, 32'h0000_0100);
        check("post rst data", seen_wdata, 32'h0000_5A5A);
    endtask : t_reset_mid

    // ************************************************************
    // Closing and main sequence
    // ************************************************************
    // One place where the run ends
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog sized well above the fewer than one hundred cycles the scenarios need
    initial begin
        #(40 * 5000);
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'h1;
        t_literal();
        t_reg_word();
        t_bytes();
        t_halves();
        t_faults();
        t_reset_mid();
        report_and_stop();
    end
endmodule : ldag_core_tb_top
